/* rtl/halt_idle_power_save.sv */
`timescale 1ns/1ps
// Purpose: HALT and IDLE power-save sequencer with Avalon-MM registers
// Assumes: clk_i is the oscillator clock; wake inputs come from same-clock logic
// Notes: Bus slave answers one cycle after a request
module halt_idle_power_save
  import power_save_pkg::*;
(
  input wire logic clk_i,                         // 200 MHz oscillator clock
  input wire logic reset_i,                       // Async reset, active high
  input wire logic [power_save_pkg::ADDR_W-1:0] address,  // Byte address
  input wire logic read,                          // Read request
  input wire logic write,                         // Write request
  input wire logic [31:0] writedata,              // Write data
  output logic [31:0] readdata,                   // Read data
  output logic waitrequest,                       // Stall
  input wire logic multi_input_wakeup_i,          // Valid wake event pulse
  input wire logic wake_block_i,                  // Enabled and pending wake
  input wire logic clock_out_pin_i,               // Clock-out pin level
  input wire logic osc_qualified_i,               // Schmitt-qualified osc
  output logic clock_in_pin_o,                    // Clock-in pin drive
  output logic clock_in_pin_oe_n_o,               // Clock-in enable, low drives
  output logic core_clk_en_o,                     // Clocks routed to core
  output logic osc_en_o,                          // Oscillator enable
  output logic timers_run_o,                      // Other timers may count
  output logic watchdog_inhibit_o,                // Watchdog detector off
  output logic supervisor_fault_output_n_o,       // Fault output, active low
  output logic idle_pending_o                     // Idle timer pending flag
);
  import power_save_pkg::*;

  // ==========================================
  // State
  typedef struct packed {
    pwr_state_type state;
    logic halt_flag;
    logic idle_flag;
    logic [3:0] cfg;
    logic tmr_pend;
    logic ack;
    logic [31:0] rdata;
    logic [2:0] ck_s;
    logic ck_lvl;
    logic [2:0] q_s;
    logic q_lvl;
  } ctl_state_type;

  ctl_state_type s_ff;
  ctl_state_type nxt_s;
  idle_timer_if tif();
  logic wr_go;
  logic rd_go;
  logic ck_rise;
  logic halt_ok;
  logic rc_sel;
  logic wake_halt;

  idle_timer u_timer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tif(tif)
  );

  // ==========================================
  // Bus strobes take effect only on the answering edge
  assign wr_go = write && s_ff.ack;
  assign rd_go = read && s_ff.ack;
  assign rc_sel = s_ff.cfg[RC_SEL_BIT];
  assign halt_ok = !s_ff.cfg[HALT_DIS_BIT];

  // Edge counts only once second and third stages agree
  assign ck_rise = (s_ff.ck_s[2] == s_ff.ck_s[1]) && s_ff.ck_s[2] && !s_ff.ck_lvl;

  // Crystal drives clock-out, so pin edge only wakes with RC
  assign wake_halt = multi_input_wakeup_i || (ck_rise && rc_sel);

  // ==========================================
  // Timer link
  always_comb begin
    tif.run = (s_ff.state != ST_HALT);
    tif.qual = s_ff.q_lvl;
    tif.load = (s_ff.state == ST_HALT) && (nxt_s.state == ST_SETTLE);
  end

  // ==========================================
  // Next state
  always_comb begin
    nxt_s = s_ff;
    nxt_s.ack = (read || write) && !s_ff.ack;

    // Pin synchronisers
    nxt_s.ck_s = {s_ff.ck_s[1:0], clock_out_pin_i};
    nxt_s.q_s = {s_ff.q_s[1:0], osc_qualified_i};
    if (s_ff.ck_s[2] == s_ff.ck_s[1]) begin
      nxt_s.ck_lvl = s_ff.ck_s[2];
    end
    if (s_ff.q_s[2] == s_ff.q_s[1]) begin
      nxt_s.q_lvl = s_ff.q_s[2];
    end

    // Read data registered on the request edge, one cycle before the answer
    if (read && !s_ff.ack) begin
      nxt_s.rdata = '0;
      if (address == MODE_OFS) begin
        nxt_s.rdata[HALT_BIT] = s_ff.halt_flag;
        nxt_s.rdata[IDLE_BIT] = s_ff.idle_flag;
      end else if (address == CFG_OFS) begin
        nxt_s.rdata[3:0] = s_ff.cfg;
      end else if (address == STAT_OFS) begin
        nxt_s.rdata[1:0] = s_ff.state;
        nxt_s.rdata[PEND_BIT] = s_ff.tmr_pend;
        nxt_s.rdata[CLKERR_BIT] = !supervisor_fault_output_n_o;
        nxt_s.rdata[BLOCK_BIT] = wake_block_i;
      end else if (address == TMR_OFS) begin
        nxt_s.rdata[15:0] = tif.value;
      end
    end

    // Register writes
    if (wr_go) begin
      if (address == CFG_OFS) begin
        nxt_s.cfg = writedata[3:0];
      end else if (address == STAT_OFS && writedata[PEND_BIT]) begin
        nxt_s.tmr_pend = 1'b0;
      end
    end

    // Pending set wins over a same-cycle clear
    if (tif.toggle) begin
      nxt_s.tmr_pend = 1'b1;
    end

    // Power state machine
    case (s_ff.state)
      ST_RUN: begin
        if (wr_go && address == MODE_OFS && !wake_block_i) begin
          if (writedata[HALT_BIT] && halt_ok) begin
            nxt_s.halt_flag = 1'b1;
            nxt_s.state = ST_HALT;
          end else if (writedata[IDLE_BIT]) begin
            nxt_s.idle_flag = 1'b1;
            nxt_s.state = ST_IDLE;
          end
        end
      end
      ST_HALT: begin
        if (wake_halt) begin
          // RC without delay select restarts at once
          if (rc_sel && !s_ff.cfg[SETTLE_SEL_BIT]) begin
            nxt_s.state = ST_RUN;
            nxt_s.halt_flag = 1'b0;
          end else begin
            nxt_s.state = ST_SETTLE;
          end
        end
      end
      ST_SETTLE: begin
        if (tif.done) begin
          nxt_s.state = ST_RUN;
          nxt_s.halt_flag = 1'b0;
        end
      end
      ST_IDLE: begin
        if (multi_input_wakeup_i || tif.toggle) begin
          nxt_s.state = ST_RUN;
          nxt_s.idle_flag = 1'b0;
        end
      end
      default: begin
        nxt_s.state = ST_RUN;
      end
    endcase
  end

  // ==========================================
  // State register; external reset also ends HALT
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_ff <= '0;
      s_ff.cfg <= CFG_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================
  // Bus answer
  assign waitrequest = (read || write) && !s_ff.ack;
  assign readdata = rd_go ? s_ff.rdata : 32'h0000_0000;

  // ==========================================
  // Clock and supervisor control
  // Core clock gated keeps RAM, registers and pins frozen
  assign core_clk_en_o = (s_ff.state == ST_RUN);
  assign timers_run_o = (s_ff.state == ST_RUN);
  // Oscillator alone runs during settle and idle
  assign osc_en_o = (s_ff.state != ST_HALT);
  assign watchdog_inhibit_o = (s_ff.state == ST_HALT);
  // Stopped oscillator is a clock monitor error when monitoring is on
  assign supervisor_fault_output_n_o =
    !(s_ff.cfg[CLKMON_BIT] && (s_ff.state == ST_HALT));
  // RC pin held high so it does not float and draw current
  assign clock_in_pin_o = 1'b1;
  assign clock_in_pin_oe_n_o = !((s_ff.state == ST_HALT) && rc_sel);
  assign idle_pending_o = s_ff.tmr_pend;
endmodule

/* rtl/idle_timer.sv */
`timescale 1ns/1ps
// Purpose: Instruction-cycle divider and idle interval timer
// Assumes: qual is already synchronised
// Notes: Counts down; toggle and done are one-cycle pulses
module idle_timer (
  input wire logic clk_i,          // Oscillator clock
  input wire logic reset_i,        // Async reset, active high
  idle_timer_if.timer tif          // Controller link
);
  import power_save_pkg::*;

  typedef struct packed {
    logic [3:0] div;
    logic [TMR_W-1:0] cnt;
    logic tc;
    logic tog;
    logic done;
  } tmr_state_type;

  tmr_state_type s_ff;
  tmr_state_type nxt_s;
  logic step;

  // ==========================================
  // Next state
  always_comb begin
    nxt_s = s_ff;
    nxt_s.tc = 1'b0;
    nxt_s.tog = 1'b0;
    nxt_s.done = 1'b0;
    // Only qualified oscillator edges advance the divider
    step = tif.run && tif.qual;
    if (step) begin
      nxt_s.div = (s_ff.div == TC_LAST) ? 4'h0 : s_ff.div + 4'h1;
      nxt_s.tc = (s_ff.div == TC_LAST);
    end
    if (tif.load) begin
      nxt_s.cnt = SETTLE_LOAD;
      nxt_s.div = 4'h0;
    end else if (s_ff.tc) begin
      nxt_s.cnt = s_ff.cnt - TMR_ONE;
      nxt_s.tog = s_ff.cnt[TMR_TOGGLE_BIT] ^ nxt_s.cnt[TMR_TOGGLE_BIT];
      nxt_s.done = (s_ff.cnt == TMR_ONE);
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tif.tc = s_ff.tc;
  assign tif.value = s_ff.cnt;
  assign tif.toggle = s_ff.tog;
  assign tif.done = s_ff.done;
endmodule

/* rtl/idle_timer_if.sv */
`timescale 1ns/1ps
// Purpose: Link between the power-save controller and its idle timer
// Assumes: Both ends on clk_i
// Notes: run gates the oscillator-side counting
interface idle_timer_if;
  logic run;
  logic load;
  logic qual;
  logic tc;
  logic [15:0] value;
  logic toggle;
  logic done;
  modport ctrl(output run, load, qual, input tc, value, toggle, done);
  modport timer(input run, load, qual, output tc, value, toggle, done);
endinterface

/* rtl/power_save_pkg.sv */
// Purpose: Shared constants and types for the power-save controller
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes: Oscillator clock is clk_i; the instruction cycle is a divided enable
package power_save_pkg;
  // ==========================================
  // Register map
  localparam logic [4:0] MODE_OFS = 5'h00;
  localparam logic [4:0] CFG_OFS = 5'h04;
  localparam logic [4:0] STAT_OFS = 5'h08;
  localparam logic [4:0] TMR_OFS = 5'h0C;
  localparam int ADDR_W = 5;

  // ==========================================
  // Field positions
  localparam int HALT_BIT = 7;
  localparam int IDLE_BIT = 6;
  localparam int SETTLE_SEL_BIT = 0;
  localparam int CLKMON_BIT = 1;
  localparam int RC_SEL_BIT = 2;
  localparam int HALT_DIS_BIT = 3;
  localparam int PEND_BIT = 2;
  localparam int CLKERR_BIT = 3;
  localparam int BLOCK_BIT = 4;

  // ==========================================
  // Reset values and timing
  localparam logic [3:0] CFG_RESET = 4'h2;
  localparam int TC_DIV = 10;
  localparam logic [3:0] TC_LAST = 4'(TC_DIV - 1);
  localparam int TMR_W = 16;
  localparam logic [TMR_W-1:0] SETTLE_LOAD = 16'h0100;
  localparam logic [TMR_W-1:0] TMR_ONE = 16'h0001;
  localparam int TMR_TOGGLE_BIT = 11;

  // ==========================================
  // Power states, Gray along run-halt-settle
  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_HALT = 2'h1,
    ST_SETTLE = 2'h3,
    ST_IDLE = 2'h2
  } pwr_state_type;
endpackage

/* verif/halt_idle_power_save_chk.sv */
// Purpose: Port checks for the power-save sequencer
// Assumes: One clock, reset_i async active high
// Notes: Settle length counts qualified cycles only
`timescale 1ns/1ps
module halt_idle_power_save_chk
  import power_save_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic reset_i, // Reset
  input wire logic [power_save_pkg::ADDR_W-1:0] address, // Address
  input wire logic write, // Write
  input wire logic [31:0] writedata, // Data
  input wire logic waitrequest, // Stall
  input wire logic multi_input_wakeup_i, // Wake
  input wire logic wake_block_i, // Block
  input wire logic clock_out_pin_i, // Pin
  input wire logic osc_qualified_i, // Qualified
  input wire logic clock_in_pin_oe_n_o, // Pin drive
  input wire logic core_clk_en_o, // Core
  input wire logic osc_en_o, // Oscillator
  input wire logic watchdog_inhibit_o, // Watchdog off
  input wire logic supervisor_fault_output_n_o // Fault
);
  // ==========================================
  // Shadow config and settle counter
  logic [3:0] cfg_ff;
  logic osc_d_ff;
  logic settling_ff;
  logic [15:0] cnt_ff;
  logic bus_wr;
  assign bus_wr = write && !waitrequest;
  // Shadow lets mode checks see halt-disable and RC select
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_ff <= CFG_RESET;
      osc_d_ff <= 1'b1;
      settling_ff <= 1'b0;
      cnt_ff <= 16'h0000;
    end else begin
      osc_d_ff <= osc_en_o;
      if (bus_wr && address == CFG_OFS) begin
        cfg_ff <= writedata[3:0];
      end
      if (core_clk_en_o) begin
        settling_ff <= 1'b0;
      end else if (osc_en_o && !osc_d_ff) begin
        settling_ff <= 1'b1;
      end
      cnt_ff <= !settling_ff ? 16'h0000 : cnt_ff + 16'(osc_qualified_i);
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence halted;
    !osc_en_o;
  endsequence
  sequence halt_req;
    bus_wr && address == MODE_OFS && writedata[HALT_BIT] && core_clk_en_o && !wake_block_i;
  endsequence
  sequence settle_done;
    $rose(core_clk_en_o) && settling_ff;
  endsequence
  a_halt_entry: assert property (halt_req ##0 !cfg_ff[HALT_DIS_BIT] |=> ##[0:1] !osc_en_o)
    else $error("halt entry");
  a_halt_refused: assert property (halt_req ##0 cfg_ff[HALT_DIS_BIT] |=> osc_en_o [*4])
    else $error("halt not refused");
  a_block_entry: assert property (bus_wr && address == MODE_OFS && core_clk_en_o
    && (writedata[HALT_BIT] || writedata[IDLE_BIT]) && wake_block_i |=> core_clk_en_o [*4])
    else $error("entry not blocked");
  a_wdog_off: assert property (watchdog_inhibit_o == !osc_en_o)
    else $error("watchdog inhibit");
  a_fault_halt: assert property (supervisor_fault_output_n_o
    == !(!osc_en_o && cfg_ff[CLKMON_BIT]))
    else $error("fault output");
  a_wake_exit: assert property (halted ##0 multi_input_wakeup_i |=> osc_en_o)
    else $error("wake exit");
  a_settle_len: assert property (settle_done |-> cnt_ff >= 16'h09EC && cnt_ff <= 16'h0A28)
    else $error("settle length");
  a_pin_drive: assert property (clock_in_pin_oe_n_o == !(!osc_en_o && cfg_ff[RC_SEL_BIT]))
    else $error("clock pin drive");
  a_pin_wake: assert property (halted ##0 cfg_ff[RC_SEL_BIT] && !cfg_ff[SETTLE_SEL_BIT]
    && $rose(clock_out_pin_i) |-> ##[1:8] core_clk_en_o)
    else $error("pin wake");
endmodule

/* verif/halt_idle_power_save_test.sv */
// Purpose: Self-checking run of the power-save sequencer
// Assumes: Bus may stall for any number of cycles
// Notes: Settle and idle waits are bounded
`timescale 1ns/1ps
module halt_idle_power_save_test;
  import power_save_pkg::*;
  // ==========================================
  // Signals
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [ADDR_W-1:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata, q, tref;
  logic waitrequest, wake, block, pin, qual, cin, oe_n, core, osc, trun, wdi, flt_n, pend;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  // Half period of 2.5 ns gives 200 MHz
  always #2.5 clk_i = ~clk_i;
  halt_idle_power_save dut_u (.clk_i, .reset_i, .address, .read, .write, .writedata,
    .readdata, .waitrequest, .multi_input_wakeup_i(wake), .wake_block_i(block),
    .clock_out_pin_i(pin), .osc_qualified_i(qual), .clock_in_pin_o(cin),
    .clock_in_pin_oe_n_o(oe_n), .core_clk_en_o(core), .osc_en_o(osc), .timers_run_o(trun),
    .watchdog_inhibit_o(wdi), .supervisor_fault_output_n_o(flt_n), .idle_pending_o(pend));
  wake_pins_model m_u (.clk_i, .wake_o(wake), .block_o(block), .pin_o(pin), .qual_o(qual));
  // ==========================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low at an edge
  // Only the bench timeout ends a stalled request
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clk_i);
    end while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  task automatic wait_core(input int lim);
    n = 0;
    while (core !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    // A wait that runs out is a failure in its own right
    if (core !== 1'b1) begin
      fails++;
    end
  endtask
  task conclude;
    if (fails == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Cut a hang short
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      fails++;
      conclude();
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(CFG_OFS, 32'hF, 32'h2);
    rd(5'h10, 32'hFFFF_FFFF, 32'h0);
    rd(TMR_OFS, 32'hFFFF, 32'h0);
    tref = q;
    repeat (97) @(posedge clk_i);
    rd(TMR_OFS, 32'hFFFF, (tref - 32'hA) & 32'hFFFF);
    bus(1'b1, CFG_OFS, 32'h8);
    bus(1'b1, MODE_OFS, 32'h80);
    rd(MODE_OFS, 32'hC0, 32'h0);
    bus(1'b1, CFG_OFS, 32'h0);
    m_u.set_block(1'b1);
    bus(1'b1, MODE_OFS, 32'hC0);
    rd(MODE_OFS, 32'hC0, 32'h0);
    rd(STAT_OFS, 32'h10, 32'h10);
    m_u.set_block(1'b0);
    // Halt with the clock monitor off, then wake through a settle
    bus(1'b1, MODE_OFS, 32'h80);
    repeat (2) @(posedge clk_i);
    chk({28'h0, osc, wdi, flt_n, core}, 32'h6);
    // Frozen count is whatever it reached, so take it as reference
    bus(1'b0, TMR_OFS, 32'h0);
    tref = q;
    repeat (97) @(posedge clk_i);
    rd(TMR_OFS, 32'hFFFF, tref);
    rd(MODE_OFS, 32'hC0, 32'h80);
    m_u.pulse_wake();
    rd(STAT_OFS, 32'h3, 32'h3);
    wait_core(4000);
    chk({31'h0, n >= 32'h9E2 && n <= 32'hA28}, 32'h1);
    rd(MODE_OFS, 32'hC0, 32'h0);
    // RC clock without delay: pin edge restarts at once
    bus(1'b1, CFG_OFS, 32'h6);
    bus(1'b1, MODE_OFS, 32'h80);
    @(posedge clk_i);
    chk({29'h0, flt_n, oe_n, cin}, 32'h1);
    rd(STAT_OFS, 32'hB, 32'h9);
    m_u.pin_rise();
    chk({31'h0, core}, 32'h1);
    // Crystal: pin edge ignored and clock pin floats
    bus(1'b1, CFG_OFS, 32'h2);
    bus(1'b1, MODE_OFS, 32'h80);
    m_u.pin_rise();
    chk({30'h0, osc, oe_n}, 32'h1);
    m_u.pulse_wake();
    wait_core(4000);
    chk({31'h0, n >= 32'h9E2 && n <= 32'hA28}, 32'h1);
    // RC with delay select: the settle waits out a weak oscillator
    bus(1'b1, CFG_OFS, 32'h5);
    bus(1'b1, MODE_OFS, 32'h80);
    m_u.pin_rise();
    m_u.starve(500);
    wait_core(4000);
    chk({31'h0, n >= 32'h9C4 && n <= 32'hA28}, 32'h1);
    // Idle ends on the timer toggle; let the wrap after settle toggle first
    repeat (20) @(posedge clk_i);
    bus(1'b1, MODE_OFS, 32'h40);
    @(posedge clk_i);
    chk({29'h0, osc, core, trun}, 32'h4);
    rd(MODE_OFS, 32'hC0, 32'h40);
    // Pending cleared inside idle, so only the ending toggle can set it
    bus(1'b1, STAT_OFS, 32'h4);
    rd(STAT_OFS, 32'h4, 32'h0);
    wait_core(21000);
    chk({30'h0, pend, core}, 32'h3);
    rd(MODE_OFS, 32'hC0, 32'h0);
    // A wake pulse ends idle as well
    bus(1'b1, MODE_OFS, 32'h40);
    m_u.pulse_wake();
    @(posedge clk_i);
    chk({31'h0, core}, 32'h1);
    // External reset ends a halt; halt wins when both flags are written
    bus(1'b1, MODE_OFS, 32'hC0);
    rd(MODE_OFS, 32'hC0, 32'h80);
    @(posedge clk_i);
    reset_i <= 1'b1;
    @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    chk({30'h0, osc, core}, 32'h3);
    rd(CFG_OFS, 32'hF, 32'h2);
    conclude();
  end
endmodule
bind halt_idle_power_save halt_idle_power_save_chk chk_u (.clk_i, .reset_i, .address, .write,
  .writedata, .waitrequest, .multi_input_wakeup_i, .wake_block_i, .clock_out_pin_i,
  .osc_qualified_i, .clock_in_pin_oe_n_o, .core_clk_en_o, .osc_en_o, .watchdog_inhibit_o,
  .supervisor_fault_output_n_o);

/* verif/wake_pins_model.sv */
// Purpose: Wake pins and oscillator qualifier beside the sequencer
// Assumes: Pins already in the oscillator clock domain
// Notes: Tasks change outputs just after a rising edge
`timescale 1ns/1ps
module wake_pins_model (
  input wire logic clk_i, // Clock
  output logic wake_o, // Wake pulse
  output logic block_o, // Wake pending
  output logic pin_o, // Clock-out pin
  output logic qual_o // Qualified osc
);
  // ==========================================
  // Pin actions
  initial begin
    wake_o = 1'b0;
    block_o = 1'b0;
    pin_o = 1'b0;
    qual_o = 1'b1;
  end
  // One-cycle event, as an edge detector gives
  task pulse_wake;
    @(posedge clk_i);
    wake_o <= 1'b1;
    @(posedge clk_i);
    wake_o <= 1'b0;
  endtask
  // Held high long enough to pass the synchroniser
  task pin_rise;
    @(posedge clk_i);
    pin_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    pin_o <= 1'b0;
  endtask
  // Weak oscillation keeps the qualifier low
  task starve(input int k);
    @(posedge clk_i);
    qual_o <= 1'b0;
    repeat (k) @(posedge clk_i);
    qual_o <= 1'b1;
  endtask
  task set_block(input logic b);
    @(posedge clk_i);
    block_o <= b;
  endtask
endmodule
